// file: core/ptpts_device.sv
`timescale 1ns/1ps
// Purpose: Egress and ingress packet timestamping beside an Ethernet MAC
// Assumes: Timer input is in this clock domain and advances on its own
// Notes: One-step commands return a timestamp but never edit the frame
module ptpts_device (
	input wire logic clk,
	input wire logic nrst,
	ptpts_if.device link,
	input wire logic [ptpts_pkg::TS_W-1:0] timer,
	input wire logic [ptpts_pkg::ADJ_W-1:0] lat_adjust,
	output logic line_tx_valid,
	output logic line_tx_sop,
	output logic line_tx_eop,
	output logic [ptpts_pkg::DATA_W-1:0] line_tx_data,
	output logic line_tx_err,
	input wire logic line_rx_ena,
	input wire logic line_rx_sop,
	input wire logic line_rx_eop,
	input wire logic [ptpts_pkg::DATA_W-1:0] line_rx_data
);

	typedef enum logic [1:0] {
		PTPTS_TX_IDLE = 2'b01,
		PTPTS_TX_FRAME = 2'b10
	} ptpts_txst_t;

	typedef struct packed {
		ptpts_txst_t tx_st;
		logic line_valid;
		logic line_sop;
		logic line_eop;
		logic [ptpts_pkg::DATA_W-1:0] line_data;
		logic line_err;
		logic ts_valid;
		logic [ptpts_pkg::TAG_W-1:0] ts_tag;
		logic [ptpts_pkg::TS_W-1:0] ts_value;
		logic rx_ena;
		logic rx_sop;
		logic rx_eop;
		logic [ptpts_pkg::DATA_W-1:0] rx_data;
		logic [ptpts_pkg::TS_W-1:0] rx_ts;
	} ptpts_dst_t;

	ptpts_dst_t s_q;
	ptpts_dst_t s_d;

	// ------------------------------------------------------------
	// Timestamp arithmetic
	// ------------------------------------------------------------
	// Adds a nanosecond correction in the build's format.
	// Time-of-day carries a nanosecond overflow into seconds; the
	// correction format adds scaled nanoseconds and wraps freely.
	function automatic logic [ptpts_pkg::TS_W-1:0] ts_add(
		input logic [ptpts_pkg::TS_W-1:0] t,
		input logic [ptpts_pkg::NS_W-1:0] corr
	);
		logic [ptpts_pkg::NS_W:0] ns_sum;
		logic [ptpts_pkg::SEC_W-1:0] sec;
		logic [ptpts_pkg::CF_W-1:0] cf;
		logic [ptpts_pkg::TS_W-1:0] r;
		ns_sum = {1'b0, t[ptpts_pkg::NS_W-1:0]} + {1'b0, corr};
		sec = t[ptpts_pkg::TS_W-1:ptpts_pkg::NS_W];
		cf = t[ptpts_pkg::CF_W-1:0] + {16'h0000, corr, 16'h0000};
		if (ptpts_pkg::FMT_CORRECTION) begin
			r = {16'h0000, cf}; // RL4 RL10
		end else begin
			if (ns_sum >= {1'b0, ptpts_pkg::NS_PER_SEC}) begin
				ns_sum = ns_sum - {1'b0, ptpts_pkg::NS_PER_SEC};
				sec = sec + 48'h0000_0000_0001;
			end
			r = {sec, ns_sum[ptpts_pkg::NS_W-1:0]}; // RL3 RL9
		end
		return r;
	endfunction

	// Timer view in the build's format, unused upper bits forced low
	logic [ptpts_pkg::TS_W-1:0] timer_fmt;
	assign timer_fmt = ptpts_pkg::FMT_CORRECTION ?
		{16'h0000, timer[ptpts_pkg::CF_W-1:0]} : timer; // RL3 RL4 RL5

	// Corrections for the two capture points
	logic [ptpts_pkg::TS_W-1:0] ts_twostep;
	logic [ptpts_pkg::TS_W-1:0] ts_onestep;
	assign ts_twostep = ts_add(timer_fmt, ptpts_pkg::TWOSTEP_CORR_NS); // RL6
	assign ts_onestep = ts_add(timer_fmt, {21'h00_0000, lat_adjust}); // RL7

	// Start word of a transmit frame, taken and stamped even inside a frame.
	// Offset and checksum flag of the command are never read: one-step
	// edits are not built, so those fields carry no meaning here and a
	// later release can pick them up without touching the link.
	logic tx_start;
	assign tx_start = link.tx_valid && link.tx_sop;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;

		// Transmit pass-through: frames leave unchanged in every mode,
		// so the FCS appended downstream always covers the final bytes.
		s_d.line_valid = link.tx_valid;
		s_d.line_sop = link.tx_valid & link.tx_sop;
		s_d.line_eop = link.tx_valid & link.tx_eop;
		s_d.line_data = link.tx_data; // RL18 RL15
		s_d.line_err = 1'b0;

		// Frame tracking flags a start inside a frame or data outside one
		case (s_q.tx_st)
			PTPTS_TX_IDLE: begin
				if (link.tx_valid && !link.tx_sop) begin
					s_d.line_err = 1'b1;
				end
				if (tx_start && !link.tx_eop) begin
					s_d.tx_st = PTPTS_TX_FRAME;
				end
			end
			PTPTS_TX_FRAME: begin
				if (tx_start) begin
					s_d.line_err = 1'b1;
				end
				if (link.tx_valid && link.tx_eop) begin
					s_d.tx_st = PTPTS_TX_IDLE;
				end
			end
			default: begin
				s_d.tx_st = PTPTS_TX_IDLE;
			end
		endcase

		// Timestamp capture on the start word, command read only there
		s_d.ts_valid = 1'b0;
		if (tx_start) begin
			case (link.tx_op)
				ptpts_pkg::PTPTS_OP_TWOSTEP: begin
					// Any frame type, no parsing of the payload
					s_d.ts_valid = 1'b1; // RL2 RL16
					s_d.ts_tag = link.tx_tag; // RL17
					s_d.ts_value = ts_twostep; // RL6 RL9 RL10
				end
				ptpts_pkg::PTPTS_OP_ONESTEP: begin
					// Insertion, correction add and checksum fix-up are not
					// built: offset and checksum flag are ignored and the
					// frame passes as is, only the timestamp comes back.
					s_d.ts_valid = 1'b1; // RL1 RL11 RL12 RL13 RL14
					s_d.ts_tag = link.tx_tag;
					s_d.ts_value = ts_onestep; // RL7 RL9 RL10
				end
				default: begin
					// No operation and the reserved code take no timestamp
					s_d.ts_valid = 1'b0; // RL18
				end
			endcase
		end

		// Receive: every frame stamped, no parsing, never disabled.
		// Stamp is kept only on start words and rides with that word.
		s_d.rx_ena = line_rx_ena; // RL21
		s_d.rx_sop = line_rx_ena & line_rx_sop;
		s_d.rx_eop = line_rx_ena & line_rx_eop;
		s_d.rx_data = line_rx_data;
		if (line_rx_ena && line_rx_sop) begin
			s_d.rx_ts = timer_fmt; // RL2 RL21 RL22
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q.tx_st <= PTPTS_TX_IDLE;
			s_q.line_valid <= 1'b0;
			s_q.line_sop <= 1'b0;
			s_q.line_eop <= 1'b0;
			s_q.line_data <= ptpts_pkg::DATA_RESET;
			s_q.line_err <= 1'b0;
			s_q.ts_valid <= 1'b0;
			s_q.ts_tag <= ptpts_pkg::TAG_RESET;
			s_q.ts_value <= ptpts_pkg::TS_RESET;
			s_q.rx_ena <= 1'b0;
			s_q.rx_sop <= 1'b0;
			s_q.rx_eop <= 1'b0;
			s_q.rx_data <= ptpts_pkg::DATA_RESET;
			s_q.rx_ts <= ptpts_pkg::TS_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------
	assign line_tx_valid = s_q.line_valid;
	assign line_tx_sop = s_q.line_sop;
	assign line_tx_eop = s_q.line_eop;
	assign line_tx_data = s_q.line_data;
	assign line_tx_err = s_q.line_err;
	assign link.ts_valid = s_q.ts_valid;
	assign link.ts_tag = s_q.ts_tag;
	assign link.ts_value = s_q.ts_value;
	assign link.rx_ena = s_q.rx_ena;
	assign link.rx_sop = s_q.rx_sop;
	assign link.rx_eop = s_q.rx_eop;
	assign link.rx_data = s_q.rx_data;
	assign link.rx_ts = s_q.rx_ts;

endmodule

// file: common/ptpts_pkg.sv
// Purpose: Shared constants and types for the packet timestamping block
// Assumes: One 10 MHz clock, 64-bit stream words, timer input in this clock domain
// Notes: Timestamp format is chosen here at build time
//
// Overview of operation
// RL1: Two-step supported; one-step returns a timestamp but never modifies frames
// RL2: Timestamp frames on transmit and receive paths
// RL3: Time-of-day: 48-bit seconds plus 32-bit nanoseconds
// RL4: Correction format: signed 64-bit scaled nanoseconds
// RL5: Timer source counts up, wraps at maximum
// RL6: Two-step timestamp always corrected to reference plane
// RL7: One-step correction set by latency adjust input
// RL8: Client gives command with every frame start
// RL9: Time-of-day: return full 80-bit timestamp
// RL10: Correction format: return 64 bits, upper zero
// RL11: One-step time-of-day insertion at command offset (not built: offset ignored, frame passes unchanged)
// RL12: One-step correction add and overwrite at offset (not built: frame passes unchanged)
// RL13: One-step frame types raw, UDP/IPv4, UDP/IPv6 (not built: no frame type parsing, frame passes unchanged)
// RL14: One-step UDP checksum incremental update (not built: checksum flag ignored)
// RL15: One-step FCS computed after all modifications
// RL16: Two-step accepts every time protocol frame type
// RL17: Two-step returns timestamp with command tag
// RL18: No operation: no timestamp, frame unchanged
// RL19: Client zeroes timestamp bytes for checksum
// RL20: Client keeps checksum-to-correction distance fixed
// RL21: Receive timestamps every frame, always active
// RL22: Receive keeps start-of-packet timestamps, 80-bit output
package ptpts_pkg;

	// ------------------------------------------------------------
	// Build options and widths
	// ------------------------------------------------------------
	localparam logic FMT_CORRECTION = 1'b0; // 0: time-of-day, 1: correction field
	localparam int DATA_W = 64;
	localparam int TS_W = 80;
	localparam int SEC_W = 48;
	localparam int NS_W = 32;
	localparam int CF_W = 64;
	localparam int TAG_W = 16;
	localparam int OFS_W = 16;
	localparam int ADJ_W = 11;
	localparam int CF_FRAC_BITS = 16;

	// ------------------------------------------------------------
	// Timing constants
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam logic [NS_W-1:0] NS_PER_SEC = 32'h3B9A_CA00;
	// Fixed offset from two-step capture point to reference plane
	localparam int TWOSTEP_CORR_TIME_NS = 200;
	localparam logic [NS_W-1:0] TWOSTEP_CORR_NS = NS_W'(TWOSTEP_CORR_TIME_NS);
	localparam int TWOSTEP_CORR_CYC = (TWOSTEP_CORR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [ADJ_W-1:0] LAT_ADJ_RESET = 11'h000;

	// ------------------------------------------------------------
	// Command encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PTPTS_OP_NOP = 2'h0,
		PTPTS_OP_ONESTEP = 2'h1,
		PTPTS_OP_TWOSTEP = 2'h2,
		PTPTS_OP_RSVD = 2'h3
	} ptpts_op_t;

	localparam logic [TS_W-1:0] TS_RESET = 80'h0000_0000_0000_0000_0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 64'h0000_0000_0000_0000;
	localparam logic [TAG_W-1:0] TAG_RESET = 16'h0000;

endpackage

// file: common/ptpts_if.sv
`timescale 1ns/1ps
// Purpose: System-side stream link between the timestamping device and client logic
// Assumes: Both ends on one clock; no back-pressure on this link
// Notes: Command fields are read only with the start-of-packet word
interface ptpts_if;
	// Transmit stream and per-frame command
	logic tx_valid;
	logic tx_sop;
	logic tx_eop;
	logic [ptpts_pkg::DATA_W-1:0] tx_data;
	ptpts_pkg::ptpts_op_t tx_op;
	logic [ptpts_pkg::TAG_W-1:0] tx_tag;
	logic [ptpts_pkg::OFS_W-1:0] tx_offset;
	logic tx_udp_upd;
	// Timestamp return for two-step and one-step frames
	logic ts_valid;
	logic [ptpts_pkg::TAG_W-1:0] ts_tag;
	logic [ptpts_pkg::TS_W-1:0] ts_value;
	// Receive stream with start-of-packet timestamp
	logic rx_ena;
	logic rx_sop;
	logic rx_eop;
	logic [ptpts_pkg::DATA_W-1:0] rx_data;
	logic [ptpts_pkg::TS_W-1:0] rx_ts;

	modport device (
		input tx_valid, tx_sop, tx_eop, tx_data, tx_op, tx_tag, tx_offset, tx_udp_upd,
		output ts_valid, ts_tag, ts_value,
		output rx_ena, rx_sop, rx_eop, rx_data, rx_ts
	);
	modport client (
		output tx_valid, tx_sop, tx_eop, tx_data, tx_op, tx_tag, tx_offset, tx_udp_upd,
		input ts_valid, ts_tag, ts_value,
		input rx_ena, rx_sop, rx_eop, rx_data, rx_ts
	);
endinterface

// file: core/ptpts_client.sv
`timescale 1ns/1ps
// Purpose: Client end that sends frames with commands and collects timestamps
// Assumes: User logic holds command fields steady with its start-of-packet word
// Notes: Checksum preparation of one-step frames is left to the user payload
module ptpts_client (
	input wire logic clk,
	input wire logic nrst,
	ptpts_if.client link,
	input wire logic usr_valid,
	input wire logic usr_sop,
	input wire logic usr_eop,
	input wire logic [ptpts_pkg::DATA_W-1:0] usr_data,
	input wire logic [1:0] usr_op,
	input wire logic [ptpts_pkg::TAG_W-1:0] usr_tag,
	input wire logic [ptpts_pkg::OFS_W-1:0] usr_offset,
	input wire logic usr_udp_upd,
	output logic usr_ts_valid,
	output logic [ptpts_pkg::TAG_W-1:0] usr_ts_tag,
	output logic [ptpts_pkg::TS_W-1:0] usr_ts_value,
	output logic usr_rx_ena,
	output logic usr_rx_sop,
	output logic usr_rx_eop,
	output logic [ptpts_pkg::DATA_W-1:0] usr_rx_data,
	output logic [ptpts_pkg::TS_W-1:0] usr_rx_ts
);

	typedef struct packed {
		logic tx_valid;
		logic tx_sop;
		logic tx_eop;
		logic [ptpts_pkg::DATA_W-1:0] tx_data;
		ptpts_pkg::ptpts_op_t tx_op;
		logic [ptpts_pkg::TAG_W-1:0] tx_tag;
		logic [ptpts_pkg::OFS_W-1:0] tx_offset;
		logic tx_udp_upd;
		logic ts_valid;
		logic [ptpts_pkg::TAG_W-1:0] ts_tag;
		logic [ptpts_pkg::TS_W-1:0] ts_value;
		logic rx_ena;
		logic rx_sop;
		logic rx_eop;
		logic [ptpts_pkg::DATA_W-1:0] rx_data;
		logic [ptpts_pkg::TS_W-1:0] rx_ts;
	} ptpts_cst_t;

	ptpts_cst_t s_q;
	ptpts_cst_t s_d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Command fields driven only on the start word, zero elsewhere
	always_comb begin
		s_d = s_q;
		s_d.tx_valid = usr_valid;
		s_d.tx_sop = usr_valid & usr_sop;
		s_d.tx_eop = usr_valid & usr_eop;
		s_d.tx_data = usr_data; // RL19 RL20
		if (usr_valid && usr_sop) begin
			s_d.tx_op = ptpts_pkg::ptpts_op_t'(usr_op); // RL8
			s_d.tx_tag = usr_tag;
			s_d.tx_offset = usr_offset;
			s_d.tx_udp_upd = usr_udp_upd & (usr_op == ptpts_pkg::PTPTS_OP_ONESTEP); // RL8
		end else begin
			s_d.tx_op = ptpts_pkg::PTPTS_OP_NOP;
			s_d.tx_tag = ptpts_pkg::TAG_RESET;
			s_d.tx_offset = '0;
			s_d.tx_udp_upd = 1'b0;
		end
		// Timestamp pulse, value held until the next one
		s_d.ts_valid = link.ts_valid;
		if (link.ts_valid) begin
			s_d.ts_tag = link.ts_tag;
			s_d.ts_value = link.ts_value;
		end
		s_d.rx_ena = link.rx_ena;
		s_d.rx_sop = link.rx_sop;
		s_d.rx_eop = link.rx_eop;
		s_d.rx_data = link.rx_data;
		s_d.rx_ts = link.rx_ts;
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.tx_valid = s_q.tx_valid;
	assign link.tx_sop = s_q.tx_sop;
	assign link.tx_eop = s_q.tx_eop;
	assign link.tx_data = s_q.tx_data;
	assign link.tx_op = s_q.tx_op;
	assign link.tx_tag = s_q.tx_tag;
	assign link.tx_offset = s_q.tx_offset;
	assign link.tx_udp_upd = s_q.tx_udp_upd;
	assign usr_ts_valid = s_q.ts_valid;
	assign usr_ts_tag = s_q.ts_tag;
	assign usr_ts_value = s_q.ts_value;
	assign usr_rx_ena = s_q.rx_ena;
	assign usr_rx_sop = s_q.rx_sop;
	assign usr_rx_eop = s_q.rx_eop;
	assign usr_rx_data = s_q.rx_data;
	assign usr_rx_ts = s_q.rx_ts;

endmodule

// file: tb/ptpts_chk.sv
// Purpose: Concurrent checks on the link between client and device ends
// Assumes: One clock, asynchronous active-low reset
// Notes: Sees only link signals, so timer-based values are judged by the bench
`timescale 1ns/1ps
module ptpts_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic tx_valid,
	input wire logic tx_sop,
	input wire ptpts_pkg::ptpts_op_t tx_op,
	input wire logic [ptpts_pkg::TAG_W-1:0] tx_tag,
	input wire logic ts_valid,
	input wire logic [ptpts_pkg::TAG_W-1:0] ts_tag,
	input wire logic [ptpts_pkg::TS_W-1:0] ts_value,
	input wire logic rx_ena,
	input wire logic rx_sop,
	input wire logic [ptpts_pkg::TS_W-1:0] rx_ts
);
	// ------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	logic sop_w;
	logic stamp_w;
	// Start word, and start word that asks for a stamp
	assign sop_w = tx_valid && tx_sop;
	assign stamp_w = sop_w && (tx_op == 2'h1 || tx_op == 2'h2);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	ts_has_cause_a: assert property (ts_valid |-> $past(stamp_w))
		else $error("stamp pulse without a stamping start word");
	twostep_tag_a: assert property (sop_w && tx_op == 2'h2
		|=> ts_valid && ts_tag == $past(tx_tag))
		else $error("two-step frame not stamped with its tag");
	nop_quiet_a: assert property (sop_w && !stamp_w |=> !ts_valid)
		else $error("stamp pulse for a no-operation frame");
	onestep_ret_a: assert property (sop_w && tx_op == 2'h1 |=> ts_valid)
		else $error("one-step frame gave no timestamp");
	tag_hold_a: assert property (!ts_valid |-> $stable(ts_tag))
		else $error("stamp tag moved without a pulse");
	value_hold_a: assert property ($changed(ts_value) |-> ts_valid)
		else $error("stamp value moved without a pulse");
	tod_ns_a: assert property (ts_valid && !ptpts_pkg::FMT_CORRECTION
		|-> ts_value[31:0] < ptpts_pkg::NS_PER_SEC)
		else $error("nanoseconds field out of range");
	cf_upper_a: assert property (ts_valid && ptpts_pkg::FMT_CORRECTION
		|-> ts_value[79:64] == 16'h0000)
		else $error("correction stamp upper bits not zero");
	rx_ts_hold_a: assert property (!(rx_ena && rx_sop) |-> $stable(rx_ts))
		else $error("receive stamp moved outside a start word");
endmodule

// file: tb/ptpts_tb.sv
// Purpose: Self-checking bench for client and device ends joined by the link
// Assumes: Timer held steady across each transmit frame so the sampled value is known
// Notes: Expected stamps are worked out here from the format and corrections
`timescale 1ns/1ps
module ptpts_tb;
	logic clk, nrst, usr_valid, usr_sop, usr_eop, usr_udp_upd, usr_ts_valid;
	logic usr_rx_ena, usr_rx_sop, usr_rx_eop, line_tx_valid, line_tx_sop, line_tx_eop;
	logic line_tx_err, line_rx_ena, line_rx_sop, line_rx_eop;
	logic [1:0] usr_op;
	logic [15:0] usr_tag, usr_offset, usr_ts_tag;
	logic [63:0] usr_data, usr_rx_data, line_tx_data, line_rx_data;
	logic [79:0] usr_ts_value, usr_rx_ts, timer;
	logic [10:0] lat_adjust;
	logic [79:0] ts_q[$], tag_q[$], wd_q[$], rx_q[$], rxd_q[$];
	int miscompares, checks, err_n;

	// ------------------------------------------------------------
	// Design ends and checker
	// ------------------------------------------------------------
	ptpts_if link_if();
	ptpts_client i_ptpts_client (.clk(clk), .nrst(nrst), .link(link_if.client),
		.usr_valid(usr_valid), .usr_sop(usr_sop), .usr_eop(usr_eop), .usr_data(usr_data),
		.usr_op(usr_op), .usr_tag(usr_tag), .usr_offset(usr_offset),
		.usr_udp_upd(usr_udp_upd), .usr_ts_valid(usr_ts_valid), .usr_ts_tag(usr_ts_tag),
		.usr_ts_value(usr_ts_value), .usr_rx_ena(usr_rx_ena), .usr_rx_sop(usr_rx_sop),
		.usr_rx_eop(usr_rx_eop), .usr_rx_data(usr_rx_data), .usr_rx_ts(usr_rx_ts));
	ptpts_device i_ptpts_device (.clk(clk), .nrst(nrst), .link(link_if.device),
		.timer(timer), .lat_adjust(lat_adjust), .line_tx_valid(line_tx_valid),
		.line_tx_sop(line_tx_sop), .line_tx_eop(line_tx_eop), .line_tx_data(line_tx_data),
		.line_tx_err(line_tx_err), .line_rx_ena(line_rx_ena), .line_rx_sop(line_rx_sop),
		.line_rx_eop(line_rx_eop), .line_rx_data(line_rx_data));
	ptpts_chk i_ptpts_chk (.clk(clk), .nrst(nrst), .tx_valid(link_if.tx_valid),
		.tx_sop(link_if.tx_sop), .tx_op(link_if.tx_op), .tx_tag(link_if.tx_tag),
		.ts_valid(link_if.ts_valid), .ts_tag(link_if.ts_tag), .ts_value(link_if.ts_value),
		.rx_ena(link_if.rx_ena), .rx_sop(link_if.rx_sop), .rx_ts(link_if.rx_ts));

	// Clock at 10 MHz
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Capture returns mid-cycle, where outputs have settled since the edge
	always @(negedge clk) begin
		if (usr_ts_valid === 1'b1) begin
			ts_q.push_back(usr_ts_value);
			tag_q.push_back(80'(usr_ts_tag));
		end
		if (line_tx_valid === 1'b1)
			wd_q.push_back(80'({line_tx_sop, line_tx_eop, line_tx_data}));
		if (usr_rx_ena === 1'b1) begin
			rx_q.push_back(usr_rx_ts);
			rxd_q.push_back(80'({usr_rx_sop, usr_rx_eop, usr_rx_data}));
		end
		if (line_tx_err === 1'b1)
			err_n++;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic check(input string what, input logic [79:0] exp, input logic [79:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Timer plus a nanosecond correction, with carry into seconds
	function automatic logic [79:0] exp_ts(input logic [79:0] t, input logic [31:0] ns);
		logic [32:0] sum;
		if (ptpts_pkg::FMT_CORRECTION)
			return {16'h0000, t[63:0] + {16'h0000, ns, 16'h0000}};
		sum = {1'b0, t[31:0]} + {1'b0, ns};
		if (sum >= {1'b0, ptpts_pkg::NS_PER_SEC})
			return {t[79:32] + 48'h0000_0000_0001, sum[31:0] - ptpts_pkg::NS_PER_SEC};
		return {t[79:32], sum[31:0]};
	endfunction
	// Leaves valid high so frames may follow back to back
	task automatic send(input logic [1:0] op, input logic [15:0] tag, input int n);
		for (int i = 0; i < n; i++) begin
			usr_valid = 1'b1;
			usr_sop = (i == 0);
			usr_eop = (i == n - 1);
			usr_data = 64'h1111_0000_0000_0000 + 64'(i);
			usr_op = (i == 0) ? op : 2'h0;
			usr_tag = (i == 0) ? tag : 16'h0000;
			usr_offset = (i == 0) ? 16'h0010 : 16'h0000;
			usr_udp_upd = (i == 0) && (op == 2'h1);
			step();
		end
	endtask
	task automatic idle(input int n);
		{usr_valid, usr_sop, usr_eop, usr_op, usr_udp_upd} = '0;
		{line_rx_ena, line_rx_sop, line_rx_eop} = '0;
		repeat (n) step();
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	// Every command code, timer just short of a seconds rollover
	task automatic t_ops();
		logic [79:0] tm;
		tm = {48'h0000_0000_1234, 32'h3B9A_C9C0};
		timer = tm;
		lat_adjust = 11'h07F;
		for (int op = 0; op < 4; op++) begin
			ts_q.delete();
			tag_q.delete();
			wd_q.delete();
			send(2'(op), 16'hA000 + 16'(op), 3);
			idle(5);
			check("stamps", 80'((op == 1) || (op == 2)), 80'(ts_q.size()));
			if (ts_q.size() > 0)
				check("stamp", exp_ts(tm, (op == 2) ? ptpts_pkg::TWOSTEP_CORR_NS :
					32'h0000_007F), ts_q[0]);
			if (op == 2)
				check("tag", 80'(16'hA000 + 16'(op)), tag_q[0]);
			check("words", 80'h3, 80'(wd_q.size()));
			foreach (wd_q[i])
				check("word", 80'({i == 0, i == 2, 64'h1111_0000_0000_0000 + 64'(i)}),
					wd_q[i]);
		end
		check("framing", 80'h0, 80'(err_n));
		$display("Test ops done");
	endtask
	// Two single-word frames back to back keep their own tags
	task automatic t_b2b();
		ts_q.delete();
		tag_q.delete();
		timer = {48'h0000_0000_0002, 32'h0000_0100};
		send(2'h2, 16'h0001, 1);
		send(2'h2, 16'h0002, 1);
		idle(5);
		check("count", 80'h2, 80'(ts_q.size()));
		check("tag a", 80'h1, tag_q[0]);
		check("tag b", 80'h2, tag_q[1]);
		check("stamp b", exp_ts(timer, ptpts_pkg::TWOSTEP_CORR_NS), ts_q[1]);
		$display("Test back to back done");
	endtask
	// Receive stamp taken at start word, held over the next word
	task automatic t_rx();
		logic [79:0] t1;
		rx_q.delete();
		rxd_q.delete();
		t1 = {48'h0000_0000_0077, 32'h0000_5000};
		timer = t1;
		{line_rx_ena, line_rx_sop, line_rx_data} = {2'b11, 64'h0000_0000_0000_00AA};
		step();
		timer = {48'h0000_0000_0078, 32'h0000_6000};
		{line_rx_sop, line_rx_eop} = 2'b01;
		step();
		idle(4);
		check("rx words", 80'h2, 80'(rx_q.size()));
		check("rx stamp", exp_ts(t1, 32'h0000_0000), rx_q[0]);
		check("rx held", exp_ts(t1, 32'h0000_0000), rx_q[1]);
		check("rx first", 80'({2'b10, 64'h0000_0000_0000_00AA}), rxd_q[0]);
		check("rx last", 80'({2'b01, 64'h0000_0000_0000_00AA}), rxd_q[1]);
		$display("Test receive done");
	endtask
	// Mid-run reset clears the held stamp, its tag and the receive stamp
	task automatic t_rst();
		idle(1);
		nrst = 1'b0;
		step();
		check("rst tag", 80'h0, 80'(usr_ts_tag));
		check("rst stamp", 80'h0, usr_ts_value);
		check("rst rx", 80'h0, usr_rx_ts);
		nrst = 1'b1;
		step();
		$display("Test reset done");
	endtask
	// Framing faults pulse the error flag once each; words still pass
	task automatic t_err();
		int e0;
		e0 = err_n;
		wd_q.delete();
		usr_valid = 1'b1;
		step();
		usr_sop = 1'b1;
		step();
		step();
		usr_sop = 1'b0;
		usr_eop = 1'b1;
		step();
		idle(5);
		check("errors", 80'h2, 80'(err_n - e0));
		check("err words", 80'h4, 80'(wd_q.size()));
		$display("Test framing done");
	endtask

	// ------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		nrst = 1'b0;
		{timer, lat_adjust, usr_data, usr_tag, usr_offset, line_rx_data} = '0;
		idle(3);
		nrst = 1'b1;
		step();
		t_ops();
		t_b2b();
		t_rx();
		t_rst();
		t_err();
		end_sim();
	end
	// Tests need well under 100 cycles; allow twenty times that
	initial begin
		#200000;
		miscompares++;
		end_sim();
	end
endmodule
